// ==== shared/pscpkg.sv ====
// shared constants, types and register map of the pump staging controller
package pscpkg;
  localparam int FREQ_W = 16; // frequency in 0.1 Hz units
  localparam int FB_W = 16; // feedback in 0.1 percent units
  localparam int TIME_W = 16; // times in 0.1 s units
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_START_FREQ = 8'h04;
  localparam logic [7:0] REG_STOP_FREQ = 8'h08;
  localparam logic [7:0] REG_START_DLY = 8'h0C;
  localparam logic [7:0] REG_STOP_DLY = 8'h10;
  localparam logic [7:0] REG_RUNUP_RAMP = 8'h14;
  localparam logic [7:0] REG_STOP_RAMP = 8'h18;
  localparam logic [7:0] REG_LOW_SPEED = 8'h1C;
  localparam logic [7:0] REG_HIGH_SPEED = 8'h20;
  localparam logic [7:0] REG_SLEEP_OFS = 8'h24;
  localparam logic [7:0] REG_SLEEP_DLY = 8'h28;
  localparam logic [7:0] REG_WAKE_THR = 8'h2C;
  localparam logic [7:0] REG_QS_THR = 8'h30;
  localparam logic [7:0] REG_QS_RAMP = 8'h34;
  localparam logic [7:0] REG_SUP_THR = 8'h38;
  localparam logic [7:0] REG_SUP_DLY = 8'h3C;
  localparam logic [7:0] REG_HYST = 8'h40;
  localparam logic [7:0] REG_FALLBACK_FREQ = 8'h44;
  localparam logic [7:0] REG_STATUS = 8'h48;
  localparam logic [7:0] REG_IRQ_STAT = 8'h4C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h50;
  localparam int NUM_REGS = 21;
  // control fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_QS_EN_BIT = 2;
  localparam int CTRL_SUP_EN_BIT = 3;
  localparam int CTRL_FB_LSB = 4;
  localparam int CTRL_FB_W = 3;
  localparam logic [2:0] FB_SEL_FREEWHEEL = 3'h1;
  localparam logic [2:0] FB_SEL_FIXED = 3'h4;
  localparam logic [7:0] FAULT_FALLBACK = 8'h0C;
  // interrupt bits
  localparam int IRQ_W = 6;
  localparam int IRQ_AUX_ON = 0;
  localparam int IRQ_AUX_OFF = 1;
  localparam int IRQ_SLEEP = 2;
  localparam int IRQ_WAKE = 3;
  localparam int IRQ_FALLBACK = 4;
  localparam int IRQ_RESUME = 5;
  // supervision margins, percent
  localparam int SUP_LO_PCT = 2;
  localparam int SUP_HI_PCT = 3;
  // time base: 0.1 s tick at 250 MHz
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // reset values
  localparam logic [FREQ_W-1:0] RST_START_FREQ = 16'h01EA; // 49.0 Hz
  localparam logic [FREQ_W-1:0] RST_STOP_FREQ = 16'h018C; // 39.6 Hz
  localparam logic [TIME_W-1:0] RST_ONE_SEC = 16'h000A;
  localparam logic [FREQ_W-1:0] RST_LOW_SPEED = 16'h015E; // 35 Hz
  localparam logic [FREQ_W-1:0] RST_HIGH_SPEED = 16'h0258; // 60 Hz
  localparam logic [FREQ_W-1:0] RST_HYST = 16'h0014; // 2 Hz
  localparam logic [FREQ_W-1:0] RST_FALLBACK = 16'h01F4; // 50 Hz
  typedef enum logic [4:0] {
    PSC_IDLE = 5'b00001,
    PSC_QUICK = 5'b00010,
    PSC_REG = 5'b00100,
    PSC_SLEEP = 5'b01000,
    PSC_FALLBACK = 5'b10000
  } psc_state_t;
  typedef struct packed {
    logic [FREQ_W-1:0] start_freq;
    logic [FREQ_W-1:0] stop_freq;
    logic [TIME_W-1:0] start_dly;
    logic [TIME_W-1:0] stop_dly;
    logic [TIME_W-1:0] runup_ramp;
    logic [TIME_W-1:0] stop_ramp;
    logic [FREQ_W-1:0] low_speed;
    logic [FREQ_W-1:0] high_speed;
    logic [FREQ_W-1:0] sleep_ofs;
    logic [TIME_W-1:0] sleep_dly;
    logic [FB_W-1:0] wake_thr;
    logic [FREQ_W-1:0] qs_thr;
    logic [TIME_W-1:0] qs_ramp;
    logic [FB_W-1:0] sup_thr;
    logic [TIME_W-1:0] sup_dly;
    logic [FREQ_W-1:0] hyst;
    logic [FREQ_W-1:0] fallback_freq;
  } psc_cfg_t;
  typedef struct packed {
    logic paddr_ok;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } psc_apb_t;
endpackage

// ==== rtl/psc_delay.sv ====
// confirmation delay counter counted in time base ticks
`timescale 1ns/1ps
module psc_delay
  import pscpkg::*;
#(
  parameter int W = TIME_W
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic cond,
  input wire logic [W-1:0] delay,
  output logic expired
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge clk)
  begin
    if (!reset_n || !cond)
    begin
      cnt_q <= '0; // R18
    end
    else if (tick && cnt_q < delay)
    begin
      cnt_q <= cnt_q + 1'b1; // R19
    end
  end
  assign expired = cond && (cnt_q >= delay);
endmodule

// ==== rtl/psc_ramp.sv ====
// linear reference ramp from present value to target over ticks
`timescale 1ns/1ps
module psc_ramp
  import pscpkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [FREQ_W-1:0] from,
  input wire logic [FREQ_W-1:0] target,
  input wire logic [TIME_W-1:0] ticks,
  output logic busy,
  output logic [FREQ_W-1:0] ref_out
);
  logic [FREQ_W-1:0] ref_q;
  logic [FREQ_W-1:0] target_q;
  logic [FREQ_W-1:0] step_q;
  logic [FREQ_W-1:0] diff;
  logic [FREQ_W-1:0] step_d;
  logic up_q;
  logic busy_q;
  always_comb
  begin
    diff = (target > from) ? target - from : from - target;
    step_d = (ticks == '0) ? diff : diff / ticks;
    if (step_d == '0)
    begin
      step_d = 16'h0001;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ref_q <= '0;
      target_q <= '0;
      step_q <= '0;
      up_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else if (load)
    begin
      ref_q <= from;
      target_q <= target;
      step_q <= step_d;
      up_q <= target > from;
      busy_q <= target != from;
    end
    else if (busy_q && tick)
    begin
      if (up_q)
      begin
        if (target_q - ref_q <= step_q)
        begin
          ref_q <= target_q;
          busy_q <= 1'b0;
        end
        else
        begin
          ref_q <= ref_q + step_q;
        end
      end
      else
      begin
        if (ref_q - target_q <= step_q)
        begin
          ref_q <= target_q;
          busy_q <= 1'b0;
        end
        else
        begin
          ref_q <= ref_q - step_q;
        end
      end
    end
  end
  assign busy = busy_q;
  assign ref_out = ref_q;
endmodule

// ==== rtl/psc_top.sv ====
// pump staging controller with apb registers and interrupt
// Summary of operation
// R1 - mode bit selects single variable pump or variable plus auxiliary
// R2 - auxiliary pump switched by one discrete logic output
// R3 - pi frequency reference compared to start and stop thresholds
// R4 - above start threshold runs start delay; start aux if still above
// R5 - on aux start ramp reference to stop frequency over run-up time
// R6 - below stop threshold runs stop delay; stop aux if still below
// R7 - on aux stop ramp reference to start frequency over stop time
// R8 - aux off and below low speed plus offset: sleep after delay
// R9 - in sleep, restart when feedback falls below wake threshold
// R10 - quick start ramps to threshold before enabling pi regulator
// R11 - near high speed with feedback below threshold*0.98 starts delay
// R12 - at delay expiry feedback below threshold*1.03 enters fallback
// R13 - freewheel fallback removes motor drive
// R14 - fallback code 04 runs fixed frequency and reports fault 12
// R15 - leave fallback once feedback rises above threshold*1.03
// R16 - in aux mode supervision active only with both pumps running
// R17 - integrator example: start 49 Hz, stop 39.6 Hz, 1 s delays
// R18 - any delay resets when its condition drops before expiry
// R19 - delays count whole ticks of a fixed time base
`timescale 1ns/1ps
module psc_top
  import pscpkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [FREQ_W-1:0] pi_freq_ref,
  input wire logic [FB_W-1:0] pi_feedback,
  output logic pi_enable,
  output logic [FREQ_W-1:0] motor_freq_cmd,
  output logic motor_drive_en,
  output logic aux_pump_logic_output,
  output logic [7:0] fault_code,
  output logic irq
);
  psc_cfg_t cfg_q;
  logic [7:0] ctrl_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_ev;
  psc_state_t state_q;
  logic aux_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [31:0] prdata_q;
  logic wr_en;
  logic rd_en;
  logic mode_aux;
  logic [2:0] fb_sel;
  logic start_exp;
  logic stop_exp;
  logic sleep_exp;
  logic sup_exp;
  logic sup_cond;
  logic sup_active;
  logic [FB_W+7:0] fb_x100;
  logic [FB_W+7:0] sup_lo;
  logic [FB_W+7:0] sup_hi;
  logic ramp_load;
  logic ramp_busy;
  logic [FREQ_W-1:0] ramp_target;
  logic [TIME_W-1:0] ramp_ticks;
  logic [FREQ_W-1:0] ramp_ref;
  logic [FREQ_W-1:0] motor_freq_q;
  logic [FREQ_W-1:0] sleep_thr;
  logic sup_arm_q;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a <= REG_IRQ_MASK);
  endfunction

  assign mode_aux = ctrl_q[CTRL_MODE_BIT]; // R1
  assign fb_sel = ctrl_q[CTRL_FB_LSB +: CTRL_FB_W];

  // time base divider
  always_ff @(posedge clk)
  begin
    if (!reset_n || tick)
    begin
      tick_cnt_q <= '0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end
  assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1); // R19

  // apb slave, zero wait
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata = prdata_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_q <= 8'h00;
      irq_mask_q <= '0;
      cfg_q.start_freq <= RST_START_FREQ; // R17
      cfg_q.stop_freq <= RST_STOP_FREQ; // R17
      cfg_q.start_dly <= RST_ONE_SEC;
      cfg_q.stop_dly <= RST_ONE_SEC;
      cfg_q.runup_ramp <= RST_ONE_SEC;
      cfg_q.stop_ramp <= RST_ONE_SEC;
      cfg_q.low_speed <= RST_LOW_SPEED;
      cfg_q.high_speed <= RST_HIGH_SPEED;
      cfg_q.sleep_ofs <= '0;
      cfg_q.sleep_dly <= RST_ONE_SEC;
      cfg_q.wake_thr <= '0;
      cfg_q.qs_thr <= '0;
      cfg_q.qs_ramp <= RST_ONE_SEC;
      cfg_q.sup_thr <= '0;
      cfg_q.sup_dly <= RST_ONE_SEC;
      cfg_q.hyst <= RST_HYST;
      cfg_q.fallback_freq <= RST_FALLBACK;
    end
    else if (wr_en)
    begin
      case (paddr)
        REG_CTRL: ctrl_q <= pwdata[7:0];
        REG_START_FREQ: cfg_q.start_freq <= pwdata[15:0];
        REG_STOP_FREQ: cfg_q.stop_freq <= pwdata[15:0];
        REG_START_DLY: cfg_q.start_dly <= pwdata[15:0];
        REG_STOP_DLY: cfg_q.stop_dly <= pwdata[15:0];
        REG_RUNUP_RAMP: cfg_q.runup_ramp <= pwdata[15:0];
        REG_STOP_RAMP: cfg_q.stop_ramp <= pwdata[15:0];
        REG_LOW_SPEED: cfg_q.low_speed <= pwdata[15:0];
        REG_HIGH_SPEED: cfg_q.high_speed <= pwdata[15:0];
        REG_SLEEP_OFS: cfg_q.sleep_ofs <= pwdata[15:0];
        REG_SLEEP_DLY: cfg_q.sleep_dly <= pwdata[15:0];
        REG_WAKE_THR: cfg_q.wake_thr <= pwdata[15:0];
        REG_QS_THR: cfg_q.qs_thr <= pwdata[15:0];
        REG_QS_RAMP: cfg_q.qs_ramp <= pwdata[15:0];
        REG_SUP_THR: cfg_q.sup_thr <= pwdata[15:0];
        REG_SUP_DLY: cfg_q.sup_dly <= pwdata[15:0];
        REG_HYST: cfg_q.hyst <= pwdata[15:0];
        REG_FALLBACK_FREQ: cfg_q.fallback_freq <= pwdata[15:0];
        REG_IRQ_MASK: irq_mask_q <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        REG_CTRL: prdata_q <= {24'h00_0000, ctrl_q};
        REG_START_FREQ: prdata_q <= {16'h0000, cfg_q.start_freq};
        REG_STOP_FREQ: prdata_q <= {16'h0000, cfg_q.stop_freq};
        REG_START_DLY: prdata_q <= {16'h0000, cfg_q.start_dly};
        REG_STOP_DLY: prdata_q <= {16'h0000, cfg_q.stop_dly};
        REG_RUNUP_RAMP: prdata_q <= {16'h0000, cfg_q.runup_ramp};
        REG_STOP_RAMP: prdata_q <= {16'h0000, cfg_q.stop_ramp};
        REG_LOW_SPEED: prdata_q <= {16'h0000, cfg_q.low_speed};
        REG_HIGH_SPEED: prdata_q <= {16'h0000, cfg_q.high_speed};
        REG_SLEEP_OFS: prdata_q <= {16'h0000, cfg_q.sleep_ofs};
        REG_SLEEP_DLY: prdata_q <= {16'h0000, cfg_q.sleep_dly};
        REG_WAKE_THR: prdata_q <= {16'h0000, cfg_q.wake_thr};
        REG_QS_THR: prdata_q <= {16'h0000, cfg_q.qs_thr};
        REG_QS_RAMP: prdata_q <= {16'h0000, cfg_q.qs_ramp};
        REG_SUP_THR: prdata_q <= {16'h0000, cfg_q.sup_thr};
        REG_SUP_DLY: prdata_q <= {16'h0000, cfg_q.sup_dly};
        REG_HYST: prdata_q <= {16'h0000, cfg_q.hyst};
        REG_FALLBACK_FREQ: prdata_q <= {16'h0000, cfg_q.fallback_freq};
        REG_STATUS: prdata_q <= {16'h0000, fault_code, 2'b00, aux_q,
                                 state_q};
        REG_IRQ_STAT: prdata_q <= {26'h000_0000, irq_stat_q};
        REG_IRQ_MASK: prdata_q <= {26'h000_0000, irq_mask_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      irq_stat_q <= '0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == REG_IRQ_STAT) ?
                     pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | irq_ev;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // staging decisions
  psc_delay u_start_dly (
    .clk(clk), .reset_n(reset_n), .tick(tick),
    .cond(state_q == PSC_REG && mode_aux && !aux_q && !ramp_busy &&
          pi_freq_ref > cfg_q.start_freq), // R3 R4
    .delay(cfg_q.start_dly), .expired(start_exp));
  psc_delay u_stop_dly (
    .clk(clk), .reset_n(reset_n), .tick(tick),
    .cond(state_q == PSC_REG && aux_q && !ramp_busy &&
          pi_freq_ref < cfg_q.stop_freq), // R3 R6
    .delay(cfg_q.stop_dly), .expired(stop_exp));
  assign sleep_thr = cfg_q.low_speed + cfg_q.sleep_ofs;
  psc_delay u_sleep_dly (
    .clk(clk), .reset_n(reset_n), .tick(tick),
    .cond(state_q == PSC_REG && !aux_q && !ramp_busy &&
          pi_freq_ref < sleep_thr), // R8
    .delay(cfg_q.sleep_dly), .expired(sleep_exp));

  // feedback supervision with 2 and 3 percent margins
  assign fb_x100 = 24'(pi_feedback) * 24'd100;
  assign sup_lo = 24'(cfg_q.sup_thr) * 24'(100 - SUP_LO_PCT);
  assign sup_hi = 24'(cfg_q.sup_thr) * 24'(100 + SUP_HI_PCT);
  assign sup_active = ctrl_q[CTRL_SUP_EN_BIT] &&
                      (!mode_aux || aux_q); // R16
  assign sup_cond = state_q == PSC_REG && sup_active &&
                    pi_freq_ref > cfg_q.high_speed - cfg_q.hyst &&
                    fb_x100 < sup_hi;
  // armed below the lower margin, held while below the upper one
  always_ff @(posedge clk)
  begin
    sup_arm_q <= reset_n && sup_cond && (fb_x100 < sup_lo || sup_arm_q);
  end
  psc_delay u_sup_dly (
    .clk(clk), .reset_n(reset_n), .tick(tick),
    .cond(sup_cond && (fb_x100 < sup_lo || sup_arm_q)), // R11
    .delay(cfg_q.sup_dly), .expired(sup_exp));

  // transfer and quick start ramps
  always_comb
  begin
    ramp_load = 1'b0;
    ramp_target = cfg_q.stop_freq;
    ramp_ticks = cfg_q.runup_ramp;
    if (start_exp)
    begin
      ramp_load = 1'b1; // R5
    end
    else if (stop_exp)
    begin
      ramp_load = 1'b1; // R7
      ramp_target = cfg_q.start_freq;
      ramp_ticks = cfg_q.stop_ramp;
    end
    else if (state_q == PSC_IDLE && ctrl_q[CTRL_RUN_BIT] &&
             ctrl_q[CTRL_QS_EN_BIT])
    begin
      ramp_load = 1'b1; // R10
      ramp_target = cfg_q.qs_thr;
      ramp_ticks = cfg_q.qs_ramp;
    end
  end
  psc_ramp u_ramp (
    .clk(clk), .reset_n(reset_n), .tick(tick), .load(ramp_load),
    .from(state_q == PSC_IDLE ? 16'h0000 : motor_freq_q),
    .target(ramp_target), .ticks(ramp_ticks),
    .busy(ramp_busy), .ref_out(ramp_ref));

  // main sequencer
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= PSC_IDLE;
      aux_q <= 1'b0;
    end
    else if (!ctrl_q[CTRL_RUN_BIT])
    begin
      state_q <= PSC_IDLE;
      aux_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        PSC_IDLE:
          state_q <= ctrl_q[CTRL_QS_EN_BIT] ? PSC_QUICK : PSC_REG;
        PSC_QUICK:
          if (!ramp_busy)
          begin
            state_q <= PSC_REG; // R10
          end
        PSC_REG:
          if (sup_exp)
          begin
            state_q <= PSC_FALLBACK; // R12
          end
          else if (start_exp)
          begin
            aux_q <= 1'b1; // R2 R4
          end
          else if (stop_exp)
          begin
            aux_q <= 1'b0; // R2 R6
          end
          else if (sleep_exp)
          begin
            state_q <= PSC_SLEEP; // R8
          end
        PSC_SLEEP:
          if (pi_feedback < cfg_q.wake_thr)
          begin
            state_q <= PSC_REG; // R9
          end
        PSC_FALLBACK:
          if (fb_x100 > sup_hi)
          begin
            state_q <= PSC_REG; // R15
          end
        default: state_q <= PSC_IDLE;
      endcase
    end
  end

  assign irq_ev[IRQ_AUX_ON] = state_q == PSC_REG && start_exp && !sup_exp;
  assign irq_ev[IRQ_AUX_OFF] = state_q == PSC_REG && stop_exp && !sup_exp &&
                               !start_exp;
  assign irq_ev[IRQ_SLEEP] = state_q == PSC_REG && sleep_exp && !sup_exp &&
                             !start_exp && !stop_exp;
  assign irq_ev[IRQ_WAKE] = state_q == PSC_SLEEP &&
                            pi_feedback < cfg_q.wake_thr &&
                            ctrl_q[CTRL_RUN_BIT];
  assign irq_ev[IRQ_FALLBACK] = state_q == PSC_REG && sup_exp &&
                                ctrl_q[CTRL_RUN_BIT];
  assign irq_ev[IRQ_RESUME] = state_q == PSC_FALLBACK && fb_x100 > sup_hi &&
                              ctrl_q[CTRL_RUN_BIT];

  // motor outputs
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      motor_freq_q <= '0;
      motor_drive_en <= 1'b0;
      pi_enable <= 1'b0;
      fault_code <= 8'h00;
      aux_pump_logic_output <= 1'b0;
    end
    else
    begin
      aux_pump_logic_output <= aux_q && mode_aux; // R2
      pi_enable <= state_q == PSC_REG && !ramp_busy; // R10
      fault_code <= 8'h00;
      motor_drive_en <= 1'b1;
      case (state_q)
        PSC_QUICK: motor_freq_q <= ramp_ref;
        PSC_REG: motor_freq_q <= ramp_busy ? ramp_ref : pi_freq_ref;
        PSC_FALLBACK:
          if (fb_sel == FB_SEL_FIXED)
          begin
            motor_freq_q <= cfg_q.fallback_freq; // R14
            fault_code <= FAULT_FALLBACK; // R14
          end
          else
          begin
            motor_freq_q <= '0;
            motor_drive_en <= 1'b0; // R13
          end
        default:
        begin
          motor_freq_q <= '0;
          motor_drive_en <= 1'b0; // R8
        end
      endcase
    end
  end
  assign motor_freq_cmd = motor_freq_q;
endmodule

// ==== sim/psc_top_assertions.sv ====
// checker for the pump staging controller top ports
`timescale 1ns/1ps
module psc_top_checker
  import pscpkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [FREQ_W-1:0] pi_freq_ref,
  input wire logic [FB_W-1:0] pi_feedback,
  input wire logic pi_enable,
  input wire logic [FREQ_W-1:0] motor_freq_cmd,
  input wire logic motor_drive_en,
  input wire logic aux_pump_logic_output,
  input wire logic [7:0] fault_code,
  input wire logic irq
);
  logic wr_ok;
  logic mode_q;
  logic [FREQ_W-1:0] start_q;
  logic [FREQ_W-1:0] stop_q;
  logic [FREQ_W-1:0] fall_q;
  logic [FB_W-1:0] sup_q;
  assign wr_ok = psel && penable && pwrite;
  // shadow copies of the configuration written over apb
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mode_q <= 1'b0;
      start_q <= RST_START_FREQ;
      stop_q <= RST_STOP_FREQ;
      fall_q <= RST_FALLBACK;
      sup_q <= 16'h0000;
    end
    else if (wr_ok)
    begin
      if (paddr == REG_CTRL)
        mode_q <= pwdata[CTRL_MODE_BIT];
      if (paddr == REG_START_FREQ)
        start_q <= pwdata[15:0];
      if (paddr == REG_STOP_FREQ)
        stop_q <= pwdata[15:0];
      if (paddr == REG_FALLBACK_FREQ)
        fall_q <= pwdata[15:0];
      if (paddr == REG_SUP_THR)
        sup_q <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence aux_on_s;
    $rose(aux_pump_logic_output);
  endsequence
  sequence fb_in_s;
    $rose(fault_code == FAULT_FALLBACK);
  endsequence
  aux_mode_only_a: assert property (aux_on_s |-> mode_q)
    else $error("aux pump started in single mode");
  aux_start_thr_a: assert property (
    aux_on_s |-> $past(pi_freq_ref, 2) > start_q)
    else $error("aux pump started below start threshold");
  aux_stop_thr_a: assert property (
    $fell(aux_pump_logic_output) |-> $past(pi_freq_ref, 2) < stop_q)
    else $error("aux pump stopped above stop threshold");
  runup_ramp_a: assert property (aux_on_s |-> ##1 !pi_enable)
    else $error("regulator enabled during transfer ramp");
  fault_value_a: assert property (
    fault_code != 8'h00 |-> fault_code == FAULT_FALLBACK)
    else $error("unexpected fault code");
  fallback_freq_a: assert property (
    fault_code == FAULT_FALLBACK && $past(fault_code) == FAULT_FALLBACK
    |-> motor_freq_cmd == fall_q)
    else $error("fallback frequency not applied");
  fallback_entry_a: assert property (
    fb_in_s |-> 32'($past(pi_feedback, 2)) * 100 < 32'(sup_q) * 103)
    else $error("fallback entered with feedback high");
  fallback_exit_a: assert property (
    $fell(fault_code == FAULT_FALLBACK)
    |-> 32'($past(pi_feedback, 2)) * 100 > 32'(sup_q) * 103)
    else $error("fallback left with feedback low");
  sup_both_pumps_a: assert property (
    fb_in_s |-> !mode_q || aux_pump_logic_output)
    else $error("supervision acted with one pump in aux mode");
endmodule
bind psc_top psc_top_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pi_freq_ref(pi_freq_ref),
  .pi_feedback(pi_feedback), .pi_enable(pi_enable),
  .motor_freq_cmd(motor_freq_cmd), .motor_drive_en(motor_drive_en),
  .aux_pump_logic_output(aux_pump_logic_output),
  .fault_code(fault_code), .irq(irq));

// ==== sim/psc_pump_model.sv ====
// pressure sensor and pump contactor model at the far side
`timescale 1ns/1ps
module psc_pump_model
  import pscpkg::*;
(
  input wire logic clk,
  input wire logic motor_drive_en,
  input wire logic aux_pump_logic_output,
  input wire logic [FB_W-1:0] press_set,
  output logic [FB_W-1:0] pi_feedback,
  output logic pumps_running
);
  // sensor and contactor respond one clock late
  always_ff @(posedge clk)
  begin
    pi_feedback <= press_set;
    pumps_running <= motor_drive_en && aux_pump_logic_output;
  end
endmodule

// ==== sim/psc_top_test.sv ====
// self-checking bench for the pump staging controller
`timescale 1ns/1ps
module psc_top_test;
  import pscpkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [FREQ_W-1:0] freq = 16'h0000;
  logic [FB_W-1:0] press = 16'h0200;
  logic [FB_W-1:0] fb;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [FREQ_W-1:0] cmd;
  logic [7:0] fault;
  logic pready, pslverr, err, pi_en, drv, aux, irq, both;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  psc_top #(.TICK_CYCLES(10)) uut (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pi_freq_ref(freq), .pi_feedback(fb), .pi_enable(pi_en),
    .motor_freq_cmd(cmd), .motor_drive_en(drv),
    .aux_pump_logic_output(aux), .fault_code(fault), .irq(irq));
  psc_pump_model pump (.clk(clk), .motor_drive_en(drv),
    .aux_pump_logic_output(aux), .press_set(press), .pi_feedback(fb),
    .pumps_running(both));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    if (penable === 1'b1)
      @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] pick(input int k);
    case (k)
      0: return {7'h00, aux};
      1: return {7'h00, drv};
      2: return {7'h00, pi_en};
      default: return fault;
    endcase
  endfunction
  // change must come after lo cycles and before hi cycles
  task automatic wait_for(input int k, input logic [7:0] v,
    input int lo, input int hi);
    int n;
    n = 0;
    while (pick(k) !== v && n < hi)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= lo && n < hi}, 32'h1);
  endtask
  // output must hold value v through n cycles
  task automatic stays(input int k, input logic [7:0] v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n)
    begin
      @(posedge clk);
      if (pick(k) !== v)
        ok = 1'b0;
    end
    chk({31'h0, ok}, 32'h1);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(0, REG_START_FREQ, 0);
    chk(rd, {16'h0, RST_START_FREQ});
    apb(0, REG_STOP_FREQ, 0);
    chk(rd, {16'h0, RST_STOP_FREQ});
    apb(0, REG_STOP_DLY, 0);
    chk(rd, {16'h0, RST_ONE_SEC});
    apb(0, 8'h54, 0);
    chk({31'h0, err}, 32'h1);
    apb(1, REG_START_DLY, 32'h2);
    apb(1, REG_STOP_DLY, 32'h2);
    apb(1, REG_RUNUP_RAMP, 32'h1);
    apb(1, REG_STOP_RAMP, 32'h1);
    apb(1, REG_SLEEP_OFS, 32'h1E);
    apb(1, REG_SLEEP_DLY, 32'h3);
    apb(1, REG_WAKE_THR, 32'h100);
    apb(1, REG_SUP_THR, 32'h200);
    apb(1, REG_SUP_DLY, 32'h2);
    apb(1, REG_IRQ_MASK, 32'h3F);
    apb(1, REG_CTRL, 32'h2);
    freq <= 16'h0200;
    stays(0, 8'h0, 60);
    apb(1, REG_CTRL, 32'h3);
    freq <= 16'h0190;
    repeat (40) @(posedge clk);
    freq <= 16'h0200;
    repeat (10) @(posedge clk);
    freq <= 16'h0190;
    stays(0, 8'h0, 40);
    freq <= 16'h0200;
    wait_for(0, 8'h1, 10, 40);
    repeat (2) @(posedge clk);
    chk({31'h0, both}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wait_for(2, 8'h1, 0, 60);
    apb(1, REG_IRQ_STAT, 32'h3F);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    freq <= 16'h0100;
    wait_for(0, 8'h0, 10, 40);
    $display("end of staging test");
    wait_for(1, 8'h0, 20, 90);
    stays(1, 8'h0, 20);
    press <= 16'h0080;
    wait_for(1, 8'h1, 0, 20);
    $display("end of sleep test");
    freq <= 16'h0258;
    apb(1, REG_CTRL, 32'h4A);
    wait_for(3, FAULT_FALLBACK, 10, 60);
    repeat (2) @(posedge clk);
    chk({16'h0, cmd}, {16'h0, RST_FALLBACK});
    press <= 16'h0220;
    wait_for(3, 8'h00, 0, 20);
    apb(1, REG_CTRL, 32'h1A);
    press <= 16'h0080;
    wait_for(1, 8'h0, 10, 60);
    chk({24'h0, fault}, 32'h0);
    press <= 16'h0220;
    wait_for(1, 8'h1, 0, 20);
    $display("end of supervision test");
    apb(1, REG_CTRL, 32'h0);
    apb(1, REG_QS_THR, 32'hC8);
    apb(1, REG_QS_RAMP, 32'h2);
    repeat (5) @(posedge clk);
    apb(1, REG_CTRL, 32'h6);
    wait_for(2, 8'h1, 10, 80);
    chk({31'h0, cmd >= 16'h00C8}, 32'h1);
    $display("end of quick start test");
    tally_and_finish();
  end
endmodule
